// *** ccs_pkg.sv ***
// Shared constants for the converter clock subsystem model.
// Assumes a single 100 MHz system clock and an 8-bit serial register map.
package ccs_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CLOCK_NOISE_CONTROL    = 12'h02B;
  localparam logic [11:0] ADDR_PLL_FEEDBACK_DIV_ONE   = 12'h03D;
  localparam logic [11:0] ADDR_PLL_FEEDBACK_DIV_TWO   = 12'h03E;
  localparam logic [11:0] ADDR_PLL_RESET_CONTROL      = 12'h05C;
  localparam logic [11:0] ADDR_VCO_CAL_CONTROL        = 12'h05D;
  localparam logic [11:0] ADDR_VCO_CALIBRATION_STATUS         = 12'h05E;
  localparam logic [11:0] ADDR_LINK_STATUS            = 12'h208;
  localparam logic [11:0] ADDR_REF_OUT_CONTROL        = 12'h030;
  localparam logic [11:0] ADDR_TRIGGER_OUTPUT_CONTROL = 12'h031;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_SYNTH_RESET   = 0;
  localparam int          BIT_CAL_ENABLE    = 0;
  localparam int          BIT_CAL_DONE      = 0;
  localparam int          BIT_SYNTH_LOCK    = 0;
  localparam int          BIT_REF_OUT_EN    = 0;
  localparam int          BIT_TRIG_EN       = 0;
  localparam int          BIT_TRIG_SRC_SER  = 1;
  localparam int          LSB_TRIG_DIV      = 4;
  localparam int          LSB_V_DIV         = 4;
  localparam logic [7:0]  RST_SYNTH_RESET   = 8'h01;
  localparam logic [7:0]  RST_DIV_ONE       = 8'h25;
  localparam logic [7:0]  RST_DIV_TWO       = 8'h10;
  localparam logic [7:0]  RST_ZERO          = 8'h00;
  localparam logic [7:0]  RST_REF_OUT       = 8'h01;
  // ----------------------------------------------------------------
  // Supported VCO divisor products
  // ----------------------------------------------------------------
  localparam logic [7:0]  VP_TEN            = 8'h0A;
  localparam logic [7:0]  VP_TWELVE         = 8'h0C;
  localparam logic [7:0]  VP_SIXTEEN        = 8'h10;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          CAL_TIME_NS       = 2000;
  localparam int          LOCK_TIME_NS      = 500;
  localparam logic [11:0] CAL_CYCLES        = 12'(CAL_TIME_NS / CLK_PERIOD_NS);
  localparam logic [11:0] LOCK_CYCLES       = 12'(LOCK_TIME_NS / CLK_PERIOD_NS);
  localparam int          POLL_GAP          = 8;

  typedef enum logic [2:0] {
    SYN_RESET   = 3'b000,
    SYN_CAL     = 3'b001,
    SYN_LOCKING = 3'b010,
    SYN_LOCKED  = 3'b011,
    SYN_BYPASS  = 3'b100
  } ccs_synth_state_type;

  typedef enum logic [3:0] {
    HS_IDLE    = 4'h0,
    HS_RST     = 4'h1,
    HS_DIV1    = 4'h2,
    HS_DIV2    = 4'h3,
    HS_NOISE   = 4'h4,
    HS_CALEN   = 4'h5,
    HS_RELEASE = 4'h6,
    HS_POLLCAL = 4'h7,
    HS_POLLLCK = 4'h8,
    HS_WAIT    = 4'h9,
    HS_DONE    = 4'hA,
    HS_FAIL    = 4'hB
  } ccs_host_state_type;

  // Product of prescaler and VCO divider fields
  function automatic logic [7:0] vp_product(input logic [7:0] div_one);
    vp_product = 8'({4'h0, div_one[3:0]} * {4'h0, div_one[7:4]});
  endfunction
endpackage

// *** ccs_if.sv ***
// Carrier joining the clock subsystem and its configuring host.
// Assumes both ends share i_clk_sys; the testbench drives clk and rst.
`timescale 1ns/10ps
interface ccs_if (
  input wire logic clk,
  input wire logic rst
);
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        pll_enable_pin;
  logic        single_ended_ref_select_pin;
  logic [1:0]  aux_clock_config_pins;
  logic        power_down_pin;

  modport device (
    input  clk, rst, addr, wdata, wr, rd,
    input  pll_enable_pin, single_ended_ref_select_pin,
    input  aux_clock_config_pins, power_down_pin,
    output rdata
  );
  modport host (
    input  clk, rst, rdata,
    output addr, wdata, wr, rd,
    output pll_enable_pin, single_ended_ref_select_pin,
    output aux_clock_config_pins, power_down_pin
  );
endinterface

// *** ccs_device.sv ***
// Clock subsystem of the converter: source selection, synthesizer sequencing,
// reference repeat, auxiliary and trigger clock outputs.
// Assumes register access through the ccs_if device modport, one clock domain;
// input clocks are sampled as synchronous levels.
`timescale 1ns/10ps
module ccs_device (
  ccs_if.device      bus,
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst,
  input  wire logic  i_diff_clock_input,
  input  wire logic  i_single_ended_clock_input,
  input  wire logic  i_timestamp_input,
  input  wire logic  i_sysref,
  input  wire logic  i_serial_line_clock,
  output logic       o_sampling_clock,
  output logic       o_sampling_from_synth,
  output logic       o_reference_repeat_output,
  output logic       o_aux_clock_out_c,
  output logic       o_aux_clock_out_d,
  output logic       o_serdes_clock_trigger_output,
  output logic       o_sysref_captured,
  output logic [7:0] o_noise_suppress,
  output logic       o_synth_locked
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] noise_q, div_one_q, div_two_q, reset_ctl_q, cal_ctl_q;
  logic [7:0] ref_ctl_q, trig_ctl_q, rdata_q;
  logic       cal_done_q, lock_q, bad_div_q;
  logic [11:0] timer_q;
  logic [7:0]  vp_div;
  ccs_pkg::ccs_synth_state_type state_q;

  assign vp_div = ccs_pkg::vp_product(div_one_q);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      noise_q     <= ccs_pkg::RST_ZERO;
      div_one_q   <= ccs_pkg::RST_DIV_ONE;
      div_two_q   <= ccs_pkg::RST_DIV_TWO;
      reset_ctl_q <= ccs_pkg::RST_SYNTH_RESET;
      cal_ctl_q   <= ccs_pkg::RST_ZERO;
      ref_ctl_q   <= ccs_pkg::RST_REF_OUT;
      trig_ctl_q  <= ccs_pkg::RST_ZERO;
    end else if (bus.wr) begin
      case (bus.addr)
        ccs_pkg::ADDR_CLOCK_NOISE_CONTROL:    noise_q     <= bus.wdata;
        ccs_pkg::ADDR_PLL_FEEDBACK_DIV_ONE:   div_one_q   <= bus.wdata;
        ccs_pkg::ADDR_PLL_FEEDBACK_DIV_TWO:   div_two_q   <= bus.wdata;
        ccs_pkg::ADDR_PLL_RESET_CONTROL:      reset_ctl_q <= bus.wdata;
        ccs_pkg::ADDR_VCO_CAL_CONTROL:        cal_ctl_q   <= bus.wdata;
        ccs_pkg::ADDR_REF_OUT_CONTROL:        ref_ctl_q   <= bus.wdata;
        ccs_pkg::ADDR_TRIGGER_OUTPUT_CONTROL: trig_ctl_q  <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= ccs_pkg::RST_ZERO;
    end else if (bus.rd) begin
      case (bus.addr)
        ccs_pkg::ADDR_CLOCK_NOISE_CONTROL:    rdata_q <= noise_q;
        ccs_pkg::ADDR_PLL_FEEDBACK_DIV_ONE:   rdata_q <= div_one_q;
        ccs_pkg::ADDR_PLL_FEEDBACK_DIV_TWO:   rdata_q <= div_two_q;
        ccs_pkg::ADDR_PLL_RESET_CONTROL:      rdata_q <= reset_ctl_q;
        ccs_pkg::ADDR_VCO_CAL_CONTROL:        rdata_q <= cal_ctl_q;
        ccs_pkg::ADDR_VCO_CALIBRATION_STATUS:         rdata_q <= {7'h00, cal_done_q};
        ccs_pkg::ADDR_LINK_STATUS:            rdata_q <= {7'h00, lock_q};
        ccs_pkg::ADDR_REF_OUT_CONTROL:        rdata_q <= ref_ctl_q;
        ccs_pkg::ADDR_TRIGGER_OUTPUT_CONTROL: rdata_q <= trig_ctl_q;
        default:                              rdata_q <= ccs_pkg::RST_ZERO;
      endcase
    end else begin
      rdata_q <= ccs_pkg::RST_ZERO;
    end
  end
  assign bus.rdata = rdata_q;

  // ----------------------------------------------------------------
  // Synthesizer sequencing
  // ----------------------------------------------------------------
  // Lock is withheld for divisor products outside the supported set,
  // so a host sees a missing lock rather than a wrong rate.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bad_div_q <= 1'b0;
    end else begin
      bad_div_q <= !(vp_div == ccs_pkg::VP_TEN || vp_div == ccs_pkg::VP_TWELVE ||
                     vp_div == ccs_pkg::VP_SIXTEEN) || (div_two_q == 8'h00);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q    <= ccs_pkg::SYN_RESET;
      timer_q    <= 12'h000;
      cal_done_q <= 1'b0;
      lock_q     <= 1'b0;
    end else if (!bus.pll_enable_pin || bus.power_down_pin) begin
      state_q    <= ccs_pkg::SYN_BYPASS;
      cal_done_q <= 1'b0;
      lock_q     <= 1'b0;
    end else if (reset_ctl_q[ccs_pkg::BIT_SYNTH_RESET]) begin
      state_q    <= ccs_pkg::SYN_RESET;
      cal_done_q <= 1'b0;
      lock_q     <= 1'b0;
    end else begin
      case (state_q)
        ccs_pkg::SYN_RESET, ccs_pkg::SYN_BYPASS: begin
          timer_q <= 12'h000;
          if (cal_ctl_q[ccs_pkg::BIT_CAL_ENABLE]) begin
            state_q <= ccs_pkg::SYN_CAL;
          end else begin
            cal_done_q <= 1'b1;
            state_q    <= ccs_pkg::SYN_LOCKING;
          end
        end
        ccs_pkg::SYN_CAL: begin
          timer_q <= timer_q + 12'h001;
          if (timer_q == ccs_pkg::CAL_CYCLES - 12'h001) begin
            cal_done_q <= 1'b1;
            timer_q    <= 12'h000;
            state_q    <= ccs_pkg::SYN_LOCKING;
          end
        end
        ccs_pkg::SYN_LOCKING: begin
          if (!bad_div_q) begin
            timer_q <= timer_q + 12'h001;
          end
          if (!bad_div_q && timer_q == ccs_pkg::LOCK_CYCLES - 12'h001) begin
            lock_q  <= 1'b1;
            state_q <= ccs_pkg::SYN_LOCKED;
          end
        end
        ccs_pkg::SYN_LOCKED: lock_q <= 1'b1;
        default: state_q <= ccs_pkg::SYN_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock selection and outputs
  // ----------------------------------------------------------------
  logic ref_sel, synth_clk_q, ser_clk;
  logic [1:0] aux_div_q;
  logic [7:0] trig_cnt_q;
  logic trig_clk_q;
  logic [1:0] aux_mode;

  // Reference from single-ended pin whenever its select pin is high, in bypass too
  assign ref_sel = bus.single_ended_ref_select_pin ? i_single_ended_clock_input
                                                   : i_diff_clock_input;
  // Serializer clock is the line clock gated by the sampling source
  assign ser_clk = i_serial_line_clock & o_sampling_clock;
  assign aux_mode = bus.aux_clock_config_pins;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      synth_clk_q <= 1'b0;
    end else if (lock_q) begin
      synth_clk_q <= ~synth_clk_q;
    end else begin
      synth_clk_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      aux_div_q <= 2'h0;
    end else if (ref_sel) begin
      aux_div_q <= aux_div_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      trig_cnt_q <= 8'h00;
      trig_clk_q <= 1'b0;
    end else if (ser_clk) begin
      if (trig_cnt_q + 8'h01 >= {4'h0, trig_ctl_q[7:ccs_pkg::LSB_TRIG_DIV]}) begin
        trig_cnt_q <= 8'h00;
        trig_clk_q <= ~trig_clk_q;
      end else begin
        trig_cnt_q <= trig_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sampling_clock              <= 1'b0;
      o_sampling_from_synth         <= 1'b0;
      o_reference_repeat_output     <= 1'b0;
      o_aux_clock_out_c             <= 1'b0;
      o_aux_clock_out_d             <= 1'b0;
      o_serdes_clock_trigger_output <= 1'b0;
      o_sysref_captured             <= 1'b0;
      o_noise_suppress              <= 8'h00;
      o_synth_locked                <= 1'b0;
    end else begin
      o_sampling_from_synth <= bus.pll_enable_pin;
      o_sampling_clock      <= bus.pll_enable_pin ? synth_clk_q
                                                  : i_diff_clock_input;
      o_sysref_captured     <= i_sysref;
      o_noise_suppress      <= noise_q;
      o_synth_locked        <= lock_q;
      o_reference_repeat_output <= ref_sel & bus.pll_enable_pin & ~bus.power_down_pin &
                                   ref_ctl_q[ccs_pkg::BIT_REF_OUT_EN];
      if (bus.power_down_pin) begin
        o_aux_clock_out_c <= 1'b0;
        o_aux_clock_out_d <= 1'b0;
      end else begin
        case (aux_mode)
          2'h1:    o_aux_clock_out_c <= ref_sel;
          2'h2:    o_aux_clock_out_c <= aux_div_q[0];
          2'h3:    o_aux_clock_out_c <= aux_div_q[1];
          default: o_aux_clock_out_c <= 1'b0;
        endcase
        o_aux_clock_out_d <= (aux_mode != 2'h0) & ref_sel;
      end
      if (bus.power_down_pin || !trig_ctl_q[ccs_pkg::BIT_TRIG_EN]) begin
        o_serdes_clock_trigger_output <= 1'b0;
      end else if (trig_ctl_q[ccs_pkg::BIT_TRIG_SRC_SER]) begin
        o_serdes_clock_trigger_output <= trig_clk_q;
      end else begin
        o_serdes_clock_trigger_output <= i_timestamp_input;
      end
    end
  end
endmodule // ccs_device

// *** ccs_host.sv ***
// Configuring host: straps the pins, programs the synthesizer, polls status.
// Assumes the device answers reads one cycle after the strobe.
`timescale 1ns/10ps
module ccs_host (
  ccs_if.host        bus,
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst,
  input  wire logic  i_start,
  input  wire logic  i_use_synth,
  input  wire logic  i_use_single_ended,
  input  wire logic [1:0] i_aux_config,
  input  wire logic  i_power_down,
  input  wire logic [7:0] i_div_one,
  input  wire logic [7:0] i_div_two,
  input  wire logic [7:0] i_noise,
  output logic       o_busy,
  output logic       o_ready,
  output logic       o_config_error
);
  ccs_pkg::ccs_host_state_type st_q;
  logic [7:0] tries_q;
  logic [3:0] gap_q;
  logic       rd_pend_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bus.pll_enable_pin              <= 1'b0;
      bus.single_ended_ref_select_pin <= 1'b0;
      bus.aux_clock_config_pins       <= 2'h0;
      bus.power_down_pin              <= 1'b0;
    end else begin
      bus.pll_enable_pin              <= i_use_synth;
      // Single-ended reference is useless in bypass
      bus.single_ended_ref_select_pin <= i_use_synth & i_use_single_ended;
      bus.aux_clock_config_pins       <= i_aux_config;
      bus.power_down_pin              <= i_power_down;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ccs_pkg::HS_IDLE;
      bus.addr <= 12'h000;
      bus.wdata <= 8'h00;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      rd_pend_q <= 1'b0;
      tries_q <= 8'h00;
      gap_q <= 4'h0;
      o_busy <= 1'b0;
      o_ready <= 1'b0;
      o_config_error <= 1'b0;
    end else begin
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      rd_pend_q <= bus.rd;
      case (st_q)
        ccs_pkg::HS_IDLE: if (i_start && i_use_synth) begin
          o_busy <= 1'b1;
          o_ready <= 1'b0;
          o_config_error <= 1'b0;
          bus.wr <= 1'b1;
          bus.addr <= ccs_pkg::ADDR_PLL_RESET_CONTROL;
          bus.wdata <= ccs_pkg::RST_SYNTH_RESET;
          st_q <= ccs_pkg::HS_DIV1;
        end
        ccs_pkg::HS_DIV1: begin
          bus.wr <= 1'b1;
          bus.addr <= ccs_pkg::ADDR_PLL_FEEDBACK_DIV_ONE;
          bus.wdata <= i_div_one;
          st_q <= ccs_pkg::HS_DIV2;
        end
        ccs_pkg::HS_DIV2: begin
          bus.wr <= 1'b1;
          bus.addr <= ccs_pkg::ADDR_PLL_FEEDBACK_DIV_TWO;
          bus.wdata <= i_div_two;
          st_q <= ccs_pkg::HS_NOISE;
        end
        ccs_pkg::HS_NOISE: begin
          bus.wr <= 1'b1;
          bus.addr <= ccs_pkg::ADDR_CLOCK_NOISE_CONTROL;
          bus.wdata <= i_noise;
          st_q <= ccs_pkg::HS_CALEN;
        end
        ccs_pkg::HS_CALEN: begin
          bus.wr <= 1'b1;
          bus.addr <= ccs_pkg::ADDR_VCO_CAL_CONTROL;
          bus.wdata <= 8'h01;
          st_q <= ccs_pkg::HS_RELEASE;
        end
        ccs_pkg::HS_RELEASE: begin
          bus.wr <= 1'b1;
          bus.addr <= ccs_pkg::ADDR_PLL_RESET_CONTROL;
          bus.wdata <= ccs_pkg::RST_ZERO;
          tries_q <= 8'h00;
          st_q <= ccs_pkg::HS_POLLCAL;
        end
        ccs_pkg::HS_POLLCAL, ccs_pkg::HS_POLLLCK: begin
          bus.rd <= 1'b1;
          bus.addr <= (st_q == ccs_pkg::HS_POLLCAL) ? ccs_pkg::ADDR_VCO_CALIBRATION_STATUS
                                                    : ccs_pkg::ADDR_LINK_STATUS;
          st_q <= ccs_pkg::HS_WAIT;
          gap_q <= 4'h0;
        end
        ccs_pkg::HS_WAIT: begin
          gap_q <= gap_q + 4'h1;
          if (rd_pend_q && bus.rdata[0]) begin
            st_q <= (bus.addr == ccs_pkg::ADDR_VCO_CALIBRATION_STATUS) ? ccs_pkg::HS_POLLLCK
                                                               : ccs_pkg::HS_DONE;
          end else if (gap_q == 4'(ccs_pkg::POLL_GAP)) begin
            tries_q <= tries_q + 8'h01;
            if (tries_q == 8'hFF) begin
              st_q <= ccs_pkg::HS_FAIL;
            end else begin
              st_q <= (bus.addr == ccs_pkg::ADDR_VCO_CALIBRATION_STATUS) ? ccs_pkg::HS_POLLCAL
                                                                 : ccs_pkg::HS_POLLLCK;
            end
          end
        end
        ccs_pkg::HS_DONE: begin
          o_busy <= 1'b0;
          o_ready <= 1'b1;
          st_q <= ccs_pkg::HS_IDLE;
        end
        ccs_pkg::HS_FAIL: begin
          o_busy <= 1'b0;
          o_config_error <= 1'b1;
          st_q <= ccs_pkg::HS_IDLE;
        end
        default: st_q <= ccs_pkg::HS_IDLE;
      endcase
    end
  end
endmodule // ccs_host

// *** ccs_link_checker_assertions.sv ***
// Checker for the host-to-device register link of the clock subsystem.
// Assumes one clock domain; sees the carrier signals as plain inputs.
`timescale 1ns/10ps
module ccs_link_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        pll_enable_pin,
  input wire logic        single_ended_ref_select_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since release; saturates so a stale count never aliases
  logic [11:0] since_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_q <= 12'hFFF;
    end else if (wr && addr == 12'h05C && !wdata[0]) begin
      since_q <= 12'h000;
    end else if (since_q != 12'hFFF) begin
      since_q <= since_q + 12'h001;
    end
  end
  sequence seq_hold;    wr && addr == 12'h05C && wdata[0];  endsequence
  sequence seq_release; wr && addr == 12'h05C && !wdata[0]; endsequence
  sequence seq_arm;     wr && addr == 12'h05D && wdata[0];  endsequence
  a_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
    else $error("read data seen without a read");
  a_strobe_excl: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_reset_first: assert property (seq_hold |=> wr && addr == 12'h03D)
    else $error("dividers not written right after reset hold");
  a_div_pair: assert property (wr && addr == 12'h03D |=> wr && addr == 12'h03E)
    else $error("feedback divider not written after prescaler");
  a_arm_release: assert property (seq_arm |=> seq_release)
    else $error("release does not follow calibration enable");
  a_cal_early: assert property (rd && addr == 12'h05E && since_q < 12'h096 |=> !rdata[0])
    else $error("calibration reported done too early");
  a_lock_poll: assert property (rd && addr == 12'h208 |-> since_q >= 12'h0BE)
    else $error("lock polled before calibration could finish");
  a_se_pll: assert property (!(single_ended_ref_select_pin && !pll_enable_pin))
    else $error("single-ended reference chosen in bypass");
endmodule // ccs_link_checker

// *** tb_top.sv ***
// Bench: host and device joined on one carrier, plus a second device
// driven from register tasks. Assumes 100 MHz clock, async high reset.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        hsyn = 1'b0;
  logic        hse = 1'b1;
  logic [7:0]  tick = 8'h00;
  wire  [7:0]  tprev = tick - 8'h01;
  int          fail_count = 0;
  int          checked = 0;
  logic [7:0]  rv;
  logic        rdy, err, lck1, lck2, syn1, syn2, ref2, auxc, auxd, smp2, trg2, busy, syr2;
  logic [7:0]  nz1, nz2;
  logic [11:0] ra [9] = '{12'h02B, 12'h03D, 12'h03E, 12'h05C, 12'h05D, 12'h05E, 12'h208,
                          12'h030, 12'h0FF};
  logic [7:0]  rr [9] = '{8'h00, 8'h25, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0]  dv [4] = '{8'h25, 8'h34, 8'h44, 8'h33};
  logic [7:0]  lk [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
  always #5 clk = ~clk;
  // Reference and side inputs are bits of one free-running count
  always @(posedge clk) tick <= tick + 8'h01;
  ccs_if bus1 (.clk(clk), .rst(rst));
  ccs_if bus2 (.clk(clk), .rst(rst));
  ccs_host ccs_host_i (.bus(bus1.host), .i_clk_sys(clk), .i_rst(rst), .i_start(start),
    .i_use_synth(hsyn), .i_use_single_ended(hse), .i_aux_config(2'h2), .i_power_down(1'b0),
    .i_div_one(8'h34), .i_div_two(8'h10), .i_noise(8'h5A), .o_busy(busy), .o_ready(rdy),
    .o_config_error(err));
  ccs_device ccs_device_i (.bus(bus1.device), .i_clk_sys(clk), .i_rst(rst),
    .i_diff_clock_input(tick[1]), .i_single_ended_clock_input(tick[2]),
    .i_timestamp_input(tick[3]), .i_sysref(tick[4]), .i_serial_line_clock(tick[0]),
    .o_sampling_clock(), .o_sampling_from_synth(syn1), .o_reference_repeat_output(),
    .o_aux_clock_out_c(), .o_aux_clock_out_d(), .o_serdes_clock_trigger_output(),
    .o_sysref_captured(), .o_noise_suppress(nz1), .o_synth_locked(lck1));
  ccs_device ccs_device_b_i (.bus(bus2.device), .i_clk_sys(clk), .i_rst(rst),
    .i_diff_clock_input(tick[1]), .i_single_ended_clock_input(tick[2]),
    .i_timestamp_input(tick[3]), .i_sysref(tick[4]), .i_serial_line_clock(tick[0]),
    .o_sampling_clock(smp2), .o_sampling_from_synth(syn2), .o_reference_repeat_output(ref2),
    .o_aux_clock_out_c(auxc), .o_aux_clock_out_d(auxd), .o_serdes_clock_trigger_output(trg2),
    .o_sysref_captured(syr2), .o_noise_suppress(nz2), .o_synth_locked(lck2));
  ccs_link_checker ccs_link_checker_i (.clk(clk), .rst(rst), .addr(bus1.addr),
    .wdata(bus1.wdata), .wr(bus1.wr), .rd(bus1.rd), .rdata(bus1.rdata),
    .pll_enable_pin(bus1.pll_enable_pin),
    .single_ended_ref_select_pin(bus1.single_ended_ref_select_pin));
  // ----------------------------------------------------------------
  // Register access and pin tasks
  // ----------------------------------------------------------------
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus2.addr  <= a;
    bus2.wdata <= d;
    bus2.wr    <= 1'b1;
    @(posedge clk);
    bus2.wr    <= 1'b0;
  endtask
  task automatic chkreg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    bus2.addr <= a;
    bus2.rd   <= 1'b1;
    @(posedge clk);
    bus2.rd   <= 1'b0;
    #1;
    `CHK(bus2.rdata, e)
  endtask
  // Three edges let the pins land and the output register follow
  task automatic pins(input logic en, input logic sel, input logic pd, input logic [1:0] cfg);
    @(posedge clk);
    bus2.pll_enable_pin              <= en;
    bus2.single_ended_ref_select_pin <= sel;
    bus2.power_down_pin              <= pd;
    bus2.aux_clock_config_pins       <= cfg;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    bus2.addr = 12'h000;
    bus2.wdata = 8'h00;
    bus2.wr = 1'b0;
    bus2.rd = 1'b0;
    bus2.pll_enable_pin = 1'b0;
    bus2.single_ended_ref_select_pin = 1'b0;
    bus2.power_down_pin = 1'b0;
    bus2.aux_clock_config_pins = 2'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 9; k++) chkreg(ra[k], rr[k]);
    wreg(12'h05E, 8'hFF);
    chkreg(12'h05E, 8'h00);
    `CHK(trg2, 1'b0)
    `CHK(bus1.single_ended_ref_select_pin, 1'b0)
    $display("test register map done");
    pins(1'b1, 1'b0, 1'b0, 2'h1);
    repeat (3) begin @(posedge clk); #1; `CHK({ref2, auxc, auxd}, {3{tprev[1]}}) end
    pins(1'b1, 1'b1, 1'b0, 2'h1);
    repeat (3) begin @(posedge clk); #1; `CHK(ref2, tprev[2]) end
    wreg(12'h030, 8'h00);
    repeat (3) begin @(posedge clk); #1; `CHK(ref2, 1'b0) end
    wreg(12'h030, 8'h01);
    pins(1'b1, 1'b0, 1'b1, 2'h1);
    repeat (3) begin @(posedge clk); #1; `CHK({ref2, auxc, auxd}, 3'h0) end
    pins(1'b0, 1'b0, 1'b0, 2'h1);
    repeat (3) begin @(posedge clk); #1; `CHK({smp2, syn2, ref2}, {tprev[1], 2'h0}) end
    repeat (2) begin @(posedge clk); #1; `CHK(syr2, tprev[4]) end
    wreg(12'h031, 8'h01);
    repeat (2) @(posedge clk);
    repeat (3) begin @(posedge clk); #1; `CHK(trg2, tprev[3]) end
    // Serial pulses come one in four cycles here; field 2 gives one rise in 16
    wreg(12'h031, 8'h23);
    repeat (8) @(posedge clk);
    #1;
    n = 0;
    for (int k = 0; k < 64; k++) begin
      rv[0] = trg2;
      @(posedge clk);
      #1;
      if (trg2 && !rv[0]) n++;
    end
    `CHK(n, 32'h4)
    $display("test pins and outputs done");
    pins(1'b1, 1'b0, 1'b0, 2'h0);
    for (int k = 0; k < 4; k++) begin
      wreg(12'h05C, 8'h01);
      wreg(12'h03D, dv[k]);
      wreg(12'h03E, 8'h10);
      wreg(12'h05D, 8'h01);
      wreg(12'h05C, 8'h00);
      repeat (100) @(posedge clk);
      chkreg(12'h05E, 8'h00);
      repeat (120) @(posedge clk);
      chkreg(12'h05E, 8'h01);
      repeat (60) @(posedge clk);
      chkreg(12'h208, lk[k]);
      `CHK(lck2, lk[k][0])
    end
    wreg(12'h02B, 8'hA5);
    chkreg(12'h02B, 8'hA5);
    `CHK(nz2, 8'hA5)
    $display("test synthesizer sequence done");
    @(posedge clk);
    hsyn  <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    `CHK(busy, 1'b1)
    // Bounded wait: a host that never finishes is a failure, not a hang
    for (n = 0; n < 5000 && rdy !== 1'b1 && err !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 5000) begin
      fail_count++;
    end else begin
      @(posedge clk);
      #1;
      `CHK({rdy, err, lck1, syn1}, 4'hB)
      `CHK(busy, 1'b0)
      `CHK(nz1, 8'h5A)
    end
    $display("test host bring-up done");
    complete_run();
  end
endmodule // tb_top
